// File: bench/timer_time_base_counter_tb_top.sv
// Self-checking bench for the time-base counter, driven over its Wishbone port.
// Assumes the registered one-cycle ack and the register map of the design package.
`timescale 1ns/100ps
module timer_time_base_counter_tb_top;
  import timer_pkg::*;

  // ************************************************************
  // Control words and signals
  // ************************************************************
  localparam logic [31:0] RUN  = 32'h1 << CTRL_RUN;
  localparam logic [31:0] DOWN = 32'h1 << CTRL_DIR;
  localparam logic [31:0] CEN  = 32'h1 << CTRL_CENTER;
  localparam logic [31:0] EXT  = 32'h1 << CTRL_SRC;
  localparam logic [31:0] UPDATE_SOURCE_CHOICE  = 32'h1 << CTRL_URS;
  localparam logic [31:0] BUF  = 32'h1 << CTRL_BUF;
  localparam logic [31:0] UPDATE_IRQ_ENABLE  = 32'h1 << CTRL_UIE;
  localparam logic [31:0] TIE  = 32'h1 << CTRL_TIE;
  localparam logic [31:0] WIE  = 32'h1 << CTRL_WIE;

  logic             sys_clk, rst, cyc, stb, we, ext_tick, slave_rst;
  logic [7:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      dat_w, dat_r, rnd;
  logic             ack, upd, top, below, irq;
  logic [CNT_W-1:0] count, cmp_sh;
  logic [31:0]      rd_q[$];
  int               fail_count, checks_done, n_top, n_below, n_upd, n, m;

  timer_time_base_counter dut (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .EXT_TICK_I(ext_tick), .SLAVE_RST_I(slave_rst), .COUNT_O(count),
    .CMP_SHADOW_O(cmp_sh), .UPDATE_EVENT_O(upd), .TOP_PULSE_O(top),
    .BELOW_ZERO_O(below), .IRQ_O(irq));

  always #5 sys_clk = ~sys_clk;

  // ************************************************************
  // Checking and reporting
  // ************************************************************
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic timeout(input string what);
    fail_count++;
    $display("mismatch %s expected done seen timeout", what);
    finish_test();
  endtask : timeout

  // Pulses are counted here so scenarios can compare totals across a window
  always @(posedge sys_clk) begin
    if (top === 1'b1) n_top++;
    if (below === 1'b1) n_below++;
    if (upd === 1'b1) n_upd++;
    if (ack === 1'b1 && we === 1'b0) begin
      if (rd_q.size() == 0) compare("read without note", 32'h0, 32'h1);
      else compare("read data", rd_q.pop_front(), dat_r);
    end
  end

  // ************************************************************
  // Bus and timing helpers
  // ************************************************************
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    do begin
      @(posedge sys_clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) timeout("bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d);
  endtask : wb_write

  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_cycle(1'b0, a, 32'h0);
  endtask : wb_read

  // Stopping first makes each start reload the repeat and down counts
  task automatic restart(input logic [31:0] c);
    wb_write(OFS_CTRL, c & ~RUN);
    wb_write(OFS_CTRL, c);
  endtask : restart

  function automatic logic sig(input int which);
    return which == 0 ? top : (which == 1 ? below : upd);
  endfunction : sig

  task automatic wait_sig(input int which, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (sig(which) !== 1'b1 && cnt < 400);
    if (sig(which) !== 1'b1) timeout("pulse wait");
  endtask : wait_sig

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, ext_tick, slave_rst} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    void'($urandom(32'h448AA9AD));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wb_read(OFS_RELOAD, 32'h0000FFFF);
    wb_read(OFS_FLAG_CLR, 32'h00000007);
    wb_read(8'hFC, 32'h0);
    // Up mode, divide 1: wrap to zero alongside the top pulse
    wb_write(OFS_RELOAD, 32'h2);
    restart(RUN | UPDATE_IRQ_ENABLE | TIE);
    for (int k = 0; k < 3; k++) begin
      wait_sig(0, n);
      compare("count at top", 32'h0, {16'h0, count});
      compare("update with top", 32'h1, {31'h0, upd});
    end
    wait_sig(0, n);
    compare("up period", 32'h3, 32'(n));
    // Flags, enables and write-zero clearing
    wb_write(OFS_CTRL, UPDATE_IRQ_ENABLE | TIE);
    wb_read(OFS_FLAGS, 32'h5);
    compare("irq raised", 32'h1, {31'h0, irq});
    wb_write(OFS_FLAG_CLR, 32'h3);
    wb_read(OFS_FLAGS, 32'h1);
    wb_write(OFS_CTRL, UPDATE_IRQ_ENABLE);
    repeat (2) @(posedge sys_clk);
    compare("irq masked", 32'h0, {31'h0, irq});
    wb_write(OFS_FLAG_CLR, 32'h0);
    wb_read(OFS_FLAGS, 32'h0);
    // Repetition gate: one update per three wraps
    wb_write(OFS_REPEAT, 32'h2);
    restart(RUN);
    wait_sig(2, n);
    @(posedge sys_clk);
    m = n_top;
    wait_sig(2, n);
    @(posedge sys_clk);
    compare("wraps per update", 32'h3, 32'(n_top - m));
    // The wait began one edge after the previous update
    compare("update spacing", 32'h9, 32'(n + 1));
    wb_write(OFS_REPEAT, 32'h0);
    // Prescaler divide by 4
    restart(RUN | (32'h2 << CTRL_PSC));
    wait_sig(0, n);
    wait_sig(0, n);
    compare("divided period", 32'hC, 32'(n));
    // Buffered reload and compare land only at the update
    wb_write(OFS_CTRL, 32'h0);
    wb_write(OFS_RELOAD, 32'h28);
    restart(RUN | BUF);
    wait_sig(0, n);
    repeat (15) @(posedge sys_clk);
    rnd = {16'h0, 16'($urandom) | 16'h0001};
    wb_write(OFS_RELOAD, 32'h5);
    wb_write(OFS_CMP, rnd);
    compare("compare shadow held", 32'h0, {16'h0, cmp_sh});
    // Shadow and top pulse are launched by the same edge
    wait_sig(0, n);
    compare("compare shadow loaded", rnd, {16'h0, cmp_sh});
    wait_sig(0, n);
    compare("buffered period", 32'h6, 32'(n));
    // Soft and slave updates follow the update source choice
    for (int u = 0; u < 2; u++) begin
      wb_write(OFS_CTRL, u[0] ? UPDATE_SOURCE_CHOICE : 32'h0);
      wb_write(OFS_COUNT, 32'h7);
      m = n_upd;
      wb_write(OFS_SOFT, 32'h1);
      slave_rst <= 1'b1;
      @(posedge sys_clk);
      slave_rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      compare("soft and slave updates", u[0] ? 32'h0 : 32'h2, 32'(n_upd - m));
      if (u == 0) compare("count after update", 32'h0, {16'h0, count});
    end
    // Down mode: reload after passing zero
    wb_write(OFS_RELOAD, 32'h3);
    restart(RUN | DOWN | WIE);
    wait_sig(1, n);
    compare("count at below", 32'h3, {16'h0, count});
    wait_sig(1, n);
    compare("down period", 32'h4, 32'(n));
    compare("wrap irq", 32'h1, {31'h0, irq});
    // Center mode: top and below alternate
    restart(RUN | CEN);
    wait_sig(0, n);
    wait_sig(1, n);
    compare("top to below", 32'h3, 32'(n));
    wait_sig(0, n);
    compare("below to top", 32'h3, 32'(n));
    // External tick, both polarities, random spacing; filter 2 on the second pass
    for (int p = 0; p < 2; p++) begin
      wb_write(OFS_CTRL, EXT);
      ext_tick <= p[0];
      wb_write(OFS_FILT, (32'(p) << FILT_POL) | 32'(2 * p));
      wb_write(OFS_COUNT, 32'h0);
      repeat (10) @(posedge sys_clk);
      wb_write(OFS_CTRL, RUN | EXT);
      m = n_top;
      repeat (6) begin
        ext_tick <= ~p[0];
        repeat (4 + $urandom % 6) @(posedge sys_clk);
        ext_tick <= p[0];
        repeat (4 + $urandom % 6) @(posedge sys_clk);
      end
      repeat (10) @(posedge sys_clk);
      compare("external wraps", 32'h1, 32'(n_top - m));
      compare("external count", 32'h2, {16'h0, count});
    end
    finish_test();
  end

endmodule : timer_time_base_counter_tb_top

// File: hw/ext_tick_filter.sv
// Synchroniser, glitch filter and edge detector for the external tick.
// Assumes the tick input is asynchronous and slower than the clock.
`timescale 1ns/100ps
module ext_tick_filter
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Settings
  input  wire logic [FILT_W-1:0] filt_i,
  input  wire logic              pol_i,
  // Tick in and out
  input  wire logic              tick_i,
  output logic                   tick_o
);

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              lvl;
    logic [FILT_W-1:0] run;
    logic              last;
    logic              tick;
  } flt_state_t;

  flt_state_t st_ff;
  flt_state_t nxt_st;
  logic       act;

  assign act    = st_ff.lvl ^ pol_i;
  assign tick_o = st_ff.tick;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = tick_i;
    nxt_st.s2   = st_ff.s1;
    if (st_ff.s2 == st_ff.lvl) begin
      nxt_st.run = '0;
    end else if (st_ff.run >= filt_i) begin
      nxt_st.lvl = st_ff.s2;
      nxt_st.run = '0;
    end else begin
      nxt_st.run = st_ff.run + 3'h1;
    end
    nxt_st.last = act;
    nxt_st.tick = act && !st_ff.last;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o) else $error("external tick longer than a cycle");

endmodule : ext_tick_filter

// File: hw/tick_prescaler.sv
// Programmable divider giving one-cycle count enables, divide by 2^sel.
// Assumes sel is steady while counting; clr_i restarts the division.
`timescale 1ns/100ps
module tick_prescaler
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic [PSC_W-1:0] sel_i,
  input  wire logic             en_i,
  input  wire logic             clr_i,
  // Enable out
  output logic                  tick_o
);

  typedef struct packed {
    logic [PSC_CNT_W-1:0] div;
  } psc_state_t;

  psc_state_t            st_ff;
  psc_state_t            nxt_st;
  logic [PSC_CNT_W-1:0]  limit;

  assign limit  = PSC_CNT_W'((8'h01 << sel_i) - 8'h01);
  // Not gated by clr_i: the update that clears the divider is itself
  // decoded from this tick, so gating here would close a loop
  assign tick_o = en_i && (st_ff.div == limit);

  always_comb begin
    nxt_st = st_ff;
    if (clr_i || !en_i || tick_o) begin
      nxt_st.div = '0;
    end else begin
      nxt_st.div = st_ff.div + 7'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_clear_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_i |=> st_ff.div == 7'h00) else $error("prescaler not cleared");

endmodule : tick_prescaler

// File: hw/timer_pkg.sv
// Constants shared by the time-base counter and its helper modules.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package timer_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FILT     = 8'h04;
  localparam logic [7:0] OFS_RELOAD   = 8'h08;
  localparam logic [7:0] OFS_COUNT    = 8'h0C;
  localparam logic [7:0] OFS_REPEAT   = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h18;
  localparam logic [7:0] OFS_SOFT     = 8'h1C;
  localparam logic [7:0] OFS_CMP      = 8'h20;
  localparam logic [7:0] OFS_CMP_ACT  = 8'h24;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_DIR    = 1;
  localparam int CTRL_CENTER = 2;
  localparam int CTRL_SRC    = 3;
  localparam int CTRL_URS    = 4;
  localparam int CTRL_BUF    = 5;
  localparam int CTRL_UIE    = 6;
  localparam int CTRL_TIE    = 7;
  localparam int CTRL_WIE    = 8;
  localparam int CTRL_PSC    = 9;
  localparam int CTRL_W      = 12;
  localparam int PSC_W       = 3;
  localparam int PSC_CNT_W   = 7;
  localparam int FILT_W      = 3;
  localparam int FILT_POL    = 3;
  localparam int FLAG_TOP    = 0;
  localparam int FLAG_WRAP   = 1;
  localparam int FLAG_UPD    = 2;
  localparam int FLAG_W      = 3;
  localparam int CNT_W       = 16;
  localparam int REP_W       = 8;
  localparam int SOFT_UPD    = 0;

  // ************************************************************
  // Reset values and flag-clear read value
  // ************************************************************
  localparam logic [CNT_W-1:0]  RELOAD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CMP_RST    = 16'h0000;
  localparam logic [FLAG_W-1:0] CLR_READ   = 3'h7;

endpackage : timer_pkg

// File: hw/timer_time_base_counter.sv
// Time-base unit: 16-bit auto-reload counter with repetition gate.
// Assumes a classic Wishbone master on the register port and a
// one-cycle slave-mode reset pulse from the trigger logic.
//
// Overview of operation
// - 16-bit auto-reload counter behind a prescaler
// - Source 0 counts divided system clock
// - Source 1 counts filtered, polarity-chosen external tick
// - Update source select: wide set or wraps
// - Update event lasts exactly one cycle
// - Update resets counter or reverses direction
// - Update copies reload and compare into shadows
// - Update clears prescaler count, not its setting
// - Update sets update flag; write 0 clears
// - Nonzero repeat: update only when exhausted
// - Modes: edge up, edge down, center
// - Edge mode direction 0 increments each tick
// - Up mode reaching reload gives one-cycle pulse
// - Next cycle zero, top flag, optional interrupt
// - Up mode update each wrap or after repeats
// - Down mode reloads, underflow pulse and flag
// - Center mode climbs to reload, falls to zero
// - Buffered reload writes land at update only while running
// - Soft or slave update immediate, reloads repeats
`timescale 1ns/100ps
module timer_time_base_counter
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic             SYS_CLK_I,
  input  wire logic             RST_I,
  // Wishbone slave
  input  wire logic             CYC_I,
  input  wire logic             STB_I,
  input  wire logic             WE_I,
  input  wire logic [7:0]       ADR_I,
  input  wire logic [3:0]       SEL_I,
  input  wire logic [31:0]      DAT_I,
  output logic      [31:0]      DAT_O,
  output logic                  ACK_O,
  // External tick and slave-mode reset
  input  wire logic             EXT_TICK_I,
  input  wire logic             SLAVE_RST_I,
  // Timer outputs
  output logic      [CNT_W-1:0] COUNT_O,
  output logic      [CNT_W-1:0] CMP_SHADOW_O,
  output logic                  UPDATE_EVENT_O,
  output logic                  TOP_PULSE_O,
  output logic                  BELOW_ZERO_O,
  output logic                  IRQ_O
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  arr_pre;
    logic [CNT_W-1:0]  arr_act;
    logic [CNT_W-1:0]  cmp_pre;
    logic [CNT_W-1:0]  cmp_act;
    logic [REP_W-1:0]  rep_cfg;
    logic [REP_W-1:0]  rep;
    logic [CTRL_W-1:0] ctrl;
    logic [3:0]        filt;
    logic              dir;
    logic [FLAG_W-1:0] flags;
    logic              upd;
    logic              top;
    logic              below_zero_pulse;
    logic              irq;
    logic              ack;
    logic [31:0]       rdat;
  } tb_state_t;

  tb_state_t         st_ff;
  tb_state_t         nxt_st;
  logic              req;
  logic              wr;
  logic [31:0]       rd_mux;
  logic [31:0]       wd;
  logic              psc_tick;
  logic              ext_tick;
  logic              tick;
  logic              run;
  logic              center;
  logic              at_top;
  logic              at_bot;
  logic              wrap;
  logic              sw_src;
  logic              hw_upd;
  logic              upd;
  logic              soft_wr;

  // Byte-lane merge: unselected lanes keep the current value
  function automatic logic [31:0] lane_merge(input logic [31:0] cur,
                                             input logic [31:0] din,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = cur;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = din[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign req     = CYC_I && STB_I && !st_ff.ack;
  assign wr      = req && WE_I;
  assign wd      = lane_merge(rd_mux, DAT_I, SEL_I);
  assign soft_wr = wr && (ADR_I == OFS_SOFT) && wd[SOFT_UPD];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ADR_I)
      OFS_CTRL: begin
        rd_mux[CTRL_W-1:0]   = st_ff.ctrl;
        rd_mux[CTRL_DIR]     = st_ff.dir;
      end
      OFS_FILT:     rd_mux[3:0]        = st_ff.filt;
      OFS_RELOAD:   rd_mux[CNT_W-1:0]  = st_ff.arr_pre;
      OFS_COUNT:    rd_mux[CNT_W-1:0]  = st_ff.cnt;
      OFS_REPEAT:   rd_mux[REP_W-1:0]  = st_ff.rep_cfg;
      OFS_FLAGS:    rd_mux[FLAG_W-1:0] = st_ff.flags;
      OFS_FLAG_CLR: rd_mux[FLAG_W-1:0] = CLR_READ;
      OFS_CMP:      rd_mux[CNT_W-1:0]  = st_ff.cmp_pre;
      OFS_CMP_ACT:  rd_mux[CNT_W-1:0]  = st_ff.cmp_act;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // Count enables
  // ************************************************************
  assign run    = st_ff.ctrl[CTRL_RUN];
  assign center = st_ff.ctrl[CTRL_CENTER];

  tick_prescaler u_psc (
    .clk_i  (SYS_CLK_I),
    .rst_i  (RST_I),
    .sel_i  (st_ff.ctrl[CTRL_PSC +: PSC_W]),
    .en_i   (run && !st_ff.ctrl[CTRL_SRC]),
    .clr_i  (upd),
    .tick_o (psc_tick)
  );

  ext_tick_filter u_ext (
    .clk_i  (SYS_CLK_I),
    .rst_i  (RST_I),
    .filt_i (st_ff.filt[FILT_W-1:0]),
    .pol_i  (st_ff.filt[FILT_POL]),
    .tick_i (EXT_TICK_I),
    .tick_o (ext_tick)
  );

  assign tick   = run && (st_ff.ctrl[CTRL_SRC] ? ext_tick : psc_tick);
  // 16-bit auto-reload wrap
  // Compared against the active shadow, so buffered reloads wait for an update
  assign at_top = tick && !st_ff.dir && (st_ff.cnt == st_ff.arr_act);
  assign at_bot = tick && st_ff.dir && (st_ff.cnt == 16'h0000);
  assign wrap   = at_top || at_bot;
  // Wraps pass only once the repeats are spent
  assign hw_upd = wrap && (st_ff.rep == 8'h00);
  // Software and slave reset only in the wide set
  assign sw_src = (soft_wr || SLAVE_RST_I) && !st_ff.ctrl[CTRL_URS];
  assign upd    = hw_upd || sw_src;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.upd = 1'b0;
    nxt_st.top = 1'b0;
    nxt_st.below_zero_pulse = 1'b0;
    nxt_st.ack = req;
    if (req) begin
      nxt_st.rdat = rd_mux;
    end

    if (at_top) begin
      // Top reached: pulse and flag next cycle
      nxt_st.top              = 1'b1;
      nxt_st.flags[FLAG_TOP]  = 1'b1;
      if (center) begin
        nxt_st.dir = 1'b1;
        nxt_st.cnt = (st_ff.cnt == 16'h0000) ? st_ff.cnt : st_ff.cnt - 16'h0001;
      end else begin
        nxt_st.cnt = 16'h0000;
      end
    end else if (at_bot) begin
      nxt_st.below_zero_pulse              = 1'b1;
      nxt_st.flags[FLAG_WRAP] = 1'b1;
      if (center) begin
        nxt_st.dir = 1'b0;
        nxt_st.cnt = (st_ff.arr_act == 16'h0000) ? st_ff.cnt : st_ff.cnt + 16'h0001;
      end else begin
        nxt_st.cnt = st_ff.arr_act;
      end
    end else if (tick) begin
      nxt_st.cnt = st_ff.dir ? st_ff.cnt - 16'h0001 : st_ff.cnt + 16'h0001;
    end

    if (wrap) begin
      nxt_st.rep = hw_upd ? st_ff.rep_cfg : st_ff.rep - 8'h01;
    end

    // Register writes
    if (wr) begin
      case (ADR_I)
        OFS_CTRL: begin
          nxt_st.ctrl = wd[CTRL_W-1:0];
          // Center mode owns the direction bit and starts upward
          if (!wd[CTRL_CENTER]) begin
            nxt_st.dir = wd[CTRL_DIR];
          end else if (!center) begin
            nxt_st.dir = 1'b0;
          end
          // Start: down mode loads reload, repeats reloaded
          if (wd[CTRL_RUN] && !run) begin
            nxt_st.rep = st_ff.rep_cfg;
            if (!wd[CTRL_CENTER] && wd[CTRL_DIR]) begin
              nxt_st.cnt = st_ff.arr_act;
            end
          end
        end
        OFS_FILT:   nxt_st.filt = wd[3:0];
        OFS_RELOAD: begin
          nxt_st.arr_pre = wd[CNT_W-1:0];
          // Unbuffered or stopped: takes effect at once
          if (!(st_ff.ctrl[CTRL_BUF] && run)) begin
            nxt_st.arr_act = wd[CNT_W-1:0];
          end
        end
        OFS_COUNT:  nxt_st.cnt     = wd[CNT_W-1:0];
        OFS_REPEAT: nxt_st.rep_cfg = wd[REP_W-1:0];
        OFS_CMP: begin
          nxt_st.cmp_pre = wd[CNT_W-1:0];
          if (!(st_ff.ctrl[CTRL_BUF] && run)) begin
            nxt_st.cmp_act = wd[CNT_W-1:0];
          end
        end
        // Writing 0 clears a flag; a flag set now still wins
        OFS_FLAG_CLR: nxt_st.flags = nxt_st.flags & (wd[FLAG_W-1:0] | {
                                     1'b0, nxt_st.flags[FLAG_WRAP] & (
                                     wrap & at_bot), nxt_st.flags[FLAG_TOP] & at_top});
        default: ;
      endcase
    end

    // Software or slave update: immediate, repeats reloaded
    if (sw_src) begin
      nxt_st.rep = st_ff.rep_cfg;
      if (center) begin
        nxt_st.dir = !st_ff.dir;
      end else begin
        nxt_st.cnt = st_ff.dir ? st_ff.arr_pre : 16'h0000;
      end
    end

    if (upd) begin
      nxt_st.upd = 1'b1;
      // Update flag, set over any clear
      nxt_st.flags[FLAG_UPD] = 1'b1;
      nxt_st.arr_act = st_ff.arr_pre;
      nxt_st.cmp_act = st_ff.cmp_pre;
    end

    nxt_st.irq = (nxt_st.flags[FLAG_UPD]  && nxt_st.ctrl[CTRL_UIE])
              || (nxt_st.flags[FLAG_TOP]  && nxt_st.ctrl[CTRL_TIE])
              || (nxt_st.flags[FLAG_WRAP] && nxt_st.ctrl[CTRL_WIE]);
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_ff         <= '0;
      st_ff.arr_pre <= RELOAD_RST;
      st_ff.arr_act <= RELOAD_RST;
      st_ff.cmp_pre <= CMP_RST;
      st_ff.cmp_act <= CMP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign DAT_O          = st_ff.rdat;
  assign ACK_O          = st_ff.ack;
  assign COUNT_O        = st_ff.cnt;
  assign CMP_SHADOW_O   = st_ff.cmp_act;
  assign UPDATE_EVENT_O = st_ff.upd;
  assign TOP_PULSE_O    = st_ff.top;
  assign BELOW_ZERO_O   = st_ff.below_zero_pulse;
  assign IRQ_O          = st_ff.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_edge_top;
    at_top && !center;
  endsequence

  sequence s_zero_pulse;
    (COUNT_O == 16'h0000) && TOP_PULSE_O ##1 !TOP_PULSE_O;
  endsequence

  a_update_one_cycle: assert property (
    UPDATE_EVENT_O |=> !UPDATE_EVENT_O) else $error("update event too long");
  a_up_wrap_zero: assert property (
    s_edge_top |=> s_zero_pulse) else $error("up wrap did not clear counter");
  a_top_flag_set: assert property (
    at_top |=> st_ff.flags[FLAG_TOP]) else $error("top flag not set");
  a_down_reload: assert property (
    at_bot && !center |=> BELOW_ZERO_O && COUNT_O == $past(st_ff.arr_act))
    else $error("down wrap did not reload");
  a_center_turn: assert property (
    at_top && center |=> st_ff.dir) else $error("center mode did not turn down");
  a_repeat_gate: assert property (
    wrap && st_ff.rep != 8'h00 && !sw_src |=> !UPDATE_EVENT_O)
    else $error("update before repeats spent");
  a_soft_update: assert property (
    soft_wr && !st_ff.ctrl[CTRL_URS] |=> UPDATE_EVENT_O && st_ff.rep == st_ff.rep_cfg)
    else $error("software update missing");
  a_update_flag: assert property (
    UPDATE_EVENT_O |-> st_ff.flags[FLAG_UPD] ##1 (IRQ_O || !st_ff.ctrl[CTRL_UIE]))
    else $error("update flag or irq missing");
  a_shadow_copy: assert property (
    upd |=> st_ff.arr_act == $past(st_ff.arr_pre)) else $error("shadow not loaded");

endmodule : timer_time_base_counter
